// ---- design/dram_refresh_ecc_control.sv ----
// Function
// - A four-bit counter tracks up to fifteen pending refreshes.
// - Refresh requests wait in the counter while the memory is busy.
// - At or above the watermark, all pending refreshes go back to back.
// - Watermark resets to eight; refresh control reads 80h, low nibble zero.
// - Five-bit delay field shifts the read strobe; reads only.
// - The strobe is delayed into the half-clock data window to sample.
// - Diagnostic enable applies the invert vector to written check bits.
// - Invert vector bit k flips check bit k of each written block.
// - Sixteen-bit diagnostic register resets to zero, inversion off.
// - A read ECC error loads the eight-bit syndrome field.
// - The syndrome stays frozen until software clears the error flag.
// - A multi-bit error after a captured single-bit one overwrites it.
// - Other errors before the flag clears are not recorded.
// - The syndrome register is read-only and resets to zero.
// - The error flag clears only through error status bit 0.
`timescale 1ns/1ps
module dram_refresh_ecc_control #(
   parameter int DQ_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [dram_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [dram_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic refresh_tick,
   input wire logic mem_busy,
   output logic refresh_issue,
   output logic [3:0] refresh_pending,
   input wire logic strobe_pin,
   input wire logic [DQ_W-1:0] dq_pin,
   input wire logic rd_en,
   output logic [DQ_W-1:0] rd_data,
   output logic rd_valid,
   input wire dram_ctl_pkg::ecc_check_t wr_check_in,
   output dram_ctl_pkg::ecc_check_t wr_check_out,
   input wire dram_ctl_pkg::ecc_err_t rd_err
);
   import dram_ctl_pkg::*;

   // Register state
   logic [WM_W-1:0] wm_reg;
   logic [DLY_W-1:0] dly_reg;
   logic diag_en_reg;
   logic [DIAG_VEC_W-1:0] diag_vec_reg;
   logic [SYN_W-1:0] syn_reg;
   logic flag_reg;
   logic multi_reg;
   ecc_check_t check_reg;

   // Write channel state
   logic aw_hold_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic w_hold_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;

   // Read channel state
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // Write decode
   wire [7:0] wr_idx = aw_addr_reg[ADDR_W-1:2];
   wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   wire wr_wm = do_write && (wr_idx == IDX_REFRESH_WM);
   wire wr_dly = do_write && (wr_idx == IDX_STROBE);
   wire wr_diag = do_write && (wr_idx == IDX_ECC_DIAG);
   wire wr_syn = do_write && (wr_idx == IDX_SYNDROME);
   wire wr_err = do_write && (wr_idx == IDX_ERR_STATUS);
   wire wr_hit = wr_wm || wr_dly || wr_diag || wr_syn || wr_err;

   // Write-one-to-clear of the error status bits, lane 0 only
   wire clr_flag = wr_err && w_strb_reg[0] &&
                   w_data_reg[ERR_FLAG_BIT];
   wire clr_multi = wr_err && w_strb_reg[0] && w_data_reg[ERR_MULTI_BIT];

   // A clear in the same cycle as a new error loses to the error
   wire flag_eff = flag_reg && !clr_flag;
   wire multi_eff = multi_reg && !clr_multi;
   wire load_first = rd_err.valid && !flag_eff;
   wire load_upgrade = rd_err.valid && flag_eff && !multi_eff &&
                       rd_err.multi;
   wire load_syn = load_first || load_upgrade;

   // Read decode
   wire [7:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire [31:0] rd_wm_word = 32'({wm_reg, 4'h0});
   wire [31:0] rd_dly_word = 32'(dly_reg);
   wire [31:0] rd_diag_word = 32'({diag_en_reg, 7'h00, diag_vec_reg});
   wire [31:0] rd_syn_word = 32'(syn_reg);
   wire [31:0] rd_err_word = 32'({multi_reg, flag_reg});
   wire rd_hit = (rd_idx == IDX_REFRESH_WM) || (rd_idx == IDX_STROBE) ||
                 (rd_idx == IDX_ECC_DIAG) || (rd_idx == IDX_SYNDROME) ||
                 (rd_idx == IDX_ERR_STATUS);
   wire [31:0] rd_word =
      (rd_idx == IDX_REFRESH_WM) ? rd_wm_word :
      (rd_idx == IDX_STROBE) ? rd_dly_word :
      (rd_idx == IDX_ECC_DIAG) ? rd_diag_word :
      (rd_idx == IDX_SYNDROME) ? rd_syn_word :
      (rd_idx == IDX_ERR_STATUS) ? rd_err_word : 32'h0000_0000;

   // Check-bit inversion only while diagnostics are enabled
   wire [DIAG_VEC_W-1:0] invert_mask =
      diag_en_reg ? diag_vec_reg : '0;

   assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
   assign s_axi_wready = !w_hold_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign wr_check_out = check_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_hold_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Control registers; reserved bits are not stored and read as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wm_reg <= RST_REFRESH_WM[WM_LSB +: WM_W];
         dly_reg <= RST_STROBE[DLY_W-1:0];
         diag_en_reg <= RST_ECC_DIAG[DIAG_EN_BIT];
         diag_vec_reg <= RST_ECC_DIAG[DIAG_VEC_W-1:0];
      end else begin
         if (wr_wm && w_strb_reg[0]) begin
            wm_reg <= w_data_reg[WM_LSB +: WM_W];
         end
         // Reserved delay codes are stored as written, not filtered
         if (wr_dly && w_strb_reg[0]) begin
            dly_reg <= w_data_reg[DLY_W-1:0];
         end
         if (wr_diag && w_strb_reg[1]) begin
            diag_en_reg <= w_data_reg[DIAG_EN_BIT];
         end
         if (wr_diag && w_strb_reg[0]) begin
            diag_vec_reg <= w_data_reg[DIAG_VEC_W-1:0];
         end
      end
   end

   // Error capture; the syndrome has no software write path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         syn_reg <= RST_SYNDROME;
         flag_reg <= 1'b0;
         multi_reg <= 1'b0;
      end else begin
         flag_reg <= flag_eff || load_syn;
         multi_reg <= load_syn ? rd_err.multi : multi_eff;
         if (load_syn) begin
            syn_reg <= rd_err.syndrome;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         check_reg <= '0;
      end else begin
         check_reg.valid <= wr_check_in.valid;
         check_reg.check <= wr_check_in.check ^ invert_mask;
      end
   end

   refresh_queue #(
      .CNT_W(WM_W)
   ) u_refresh (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(refresh_tick),
      .busy(mem_busy),
      .watermark(wm_reg),
      .issue(refresh_issue),
      .pending(refresh_pending)
   );

   strobe_sampler #(
      .DLY_W(DLY_W),
      .DQ_W(DQ_W)
   ) u_strobe (
      .aclk(aclk),
      .aresetn(aresetn),
      .strobe_pin(strobe_pin),
      .dq_pin(dq_pin),
      .rd_en(rd_en),
      .delay(dly_reg),
      .rd_data(rd_data),
      .rd_valid(rd_valid)
   );

   property p_syn_frozen;
      @(posedge aclk) disable iff (!aresetn)
      flag_reg && multi_reg && !clr_flag |=> $stable(syn_reg);
   endproperty
   a_syn_frozen: assert property (p_syn_frozen)
      else $error("syndrome changed while locked on multi-bit error");

   property p_syn_upgrade;
      @(posedge aclk) disable iff (!aresetn)
      flag_reg && !multi_reg && !clr_flag && rd_err.valid && rd_err.multi
      |=> multi_reg && (syn_reg == $past(rd_err.syndrome));
   endproperty
   a_syn_upgrade: assert property (p_syn_upgrade)
      else $error("multi-bit error did not overwrite single-bit capture");

   property p_first_capture;
      @(posedge aclk) disable iff (!aresetn)
      !flag_reg && rd_err.valid
      |=> flag_reg && (syn_reg == $past(rd_err.syndrome));
   endproperty
   a_first_capture: assert property (p_first_capture)
      else $error("first error not captured");

   property p_flag_sticky;
      @(posedge aclk) disable iff (!aresetn)
      flag_reg && !clr_flag |=> flag_reg;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("error flag dropped without software clear");

   property p_check_invert;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> wr_check_out.check == ($past(wr_check_in.check) ^
         ($past(diag_en_reg) ? $past(diag_vec_reg) : 8'h00));
   endproperty
   a_check_invert: assert property (p_check_invert)
      else $error("written check bits wrong for diagnostic setting");

   property p_wm_reset;
      @(posedge aclk)
      !aresetn |=> (rd_wm_word == 32'h0000_0080) &&
                   (rd_dly_word == 32'h0000_000a);
   endproperty
   a_wm_reset: assert property (p_wm_reset)
      else $error("control register reset value wrong");

   c_upgrade: cover property (@(posedge aclk) disable iff (!aresetn)
      load_upgrade);
   c_clear_race: cover property (@(posedge aclk) disable iff (!aresetn)
      clr_flag && rd_err.valid);
   c_diag_write: cover property (@(posedge aclk) disable iff (!aresetn)
      wr_check_in.valid && diag_en_reg && (diag_vec_reg != 8'h00));

endmodule : dram_refresh_ecc_control

// ---- design/dram_ctl_pkg.sv ----
package dram_ctl_pkg;

   // Register indices; the byte address is four times the index
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_REFRESH_WM = 8'h82;
   localparam logic [7:0] IDX_STROBE = 8'h83;
   localparam logic [7:0] IDX_ECC_DIAG = 8'h84;
   localparam logic [7:0] IDX_SYNDROME = 8'h86;
   localparam logic [7:0] IDX_ERR_STATUS = 8'hc8;

   // Reset values
   localparam logic [7:0] RST_REFRESH_WM = 8'h80;
   localparam logic [7:0] RST_STROBE = 8'h0a;
   localparam logic [15:0] RST_ECC_DIAG = 16'h0000;
   localparam logic [7:0] RST_SYNDROME = 8'h00;

   // Field layout
   localparam int WM_LSB = 4;
   localparam int WM_W = 4;
   localparam int DLY_W = 5;
   localparam int DIAG_EN_BIT = 15;
   localparam int DIAG_VEC_W = 8;
   localparam int SYN_W = 8;
   localparam int ERR_FLAG_BIT = 0;
   localparam int ERR_MULTI_BIT = 1;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic {RF_IDLE, RF_BURST} rf_state_t;

   typedef struct packed {
      logic valid;
      logic multi;
      logic [SYN_W-1:0] syndrome;
   } ecc_err_t;

   typedef struct packed {
      logic valid;
      logic [DIAG_VEC_W-1:0] check;
   } ecc_check_t;

endpackage : dram_ctl_pkg

// ---- design/refresh_queue.sv ----
`timescale 1ns/1ps
module refresh_queue #(
   parameter int CNT_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic busy,
   input wire logic [CNT_W-1:0] watermark,
   output logic issue,
   output logic [CNT_W-1:0] pending
);
   import dram_ctl_pkg::*;

   rf_state_t state_reg;
   rf_state_t state_next;
   logic [CNT_W-1:0] pending_reg;
   logic [CNT_W-1:0] pending_next;
   wire full = &pending_reg;
   wire at_mark = (pending_reg >= watermark) && (pending_reg != '0);
   // A tick at full is kept only when a refresh leaves in the same cycle
   wire inc_ok = tick && (!full || issue);
   // Burst ignores busy; otherwise refreshes wait for an idle interface
   assign issue = (pending_reg != '0) &&
                  ((state_reg == RF_BURST) || !busy);
   assign pending = pending_reg;

   always_comb begin
      pending_next = pending_reg;
      if (inc_ok && !issue) begin
         pending_next = pending_reg + 1'b1;
      end else if (!inc_ok && issue) begin
         pending_next = pending_reg - 1'b1;
      end
      state_next = state_reg;
      case (state_reg)
         RF_IDLE: begin
            if (at_mark) begin
               state_next = RF_BURST;
            end
         end
         RF_BURST: begin
            if (pending_next == '0) begin
               state_next = RF_IDLE;
            end
         end
         default: state_next = RF_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending_reg <= '0;
         state_reg <= RF_IDLE;
      end else begin
         pending_reg <= pending_next;
         state_reg <= state_next;
      end
   end

   property p_burst_drains;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg == RF_BURST) && (pending_reg != '0) |-> issue;
   endproperty
   a_burst_drains: assert property (p_burst_drains)
      else $error("burst stalled with refreshes pending");

   property p_busy_holds;
      @(posedge aclk) disable iff (!aresetn)
      busy && (state_reg == RF_IDLE) |-> !issue;
   endproperty
   a_busy_holds: assert property (p_busy_holds)
      else $error("refresh issued while busy below watermark");

   property p_saturate;
      @(posedge aclk) disable iff (!aresetn)
      full && !issue |=> full;
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("refresh counter wrapped");

   property p_mark_bursts;
      @(posedge aclk) disable iff (!aresetn)
      at_mark ##1 (pending_reg != '0) |-> issue;
   endproperty
   a_mark_bursts: assert property (p_mark_bursts)
      else $error("watermark reached without burst");

   c_burst: cover property (@(posedge aclk) disable iff (!aresetn)
      (state_reg == RF_BURST) && busy && issue);

endmodule : refresh_queue

// ---- design/strobe_sampler.sv ----
`timescale 1ns/1ps
module strobe_sampler #(
   parameter int DLY_W = 5,
   parameter int DQ_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic strobe_pin,
   input wire logic [DQ_W-1:0] dq_pin,
   input wire logic rd_en,
   input wire logic [DLY_W-1:0] delay,
   output logic [DQ_W-1:0] rd_data,
   output logic rd_valid
);
   localparam int DEPTH = 1 << DLY_W;

   logic [1:0] strobe_sync_reg;
   logic strobe_last_reg;
   logic [DQ_W-1:0] dq_meta_reg;
   logic [DQ_W-1:0] dq_sync_reg;
   logic [DEPTH-2:0] line_reg;
   logic [DQ_W-1:0] data_reg;
   logic valid_reg;

   // Both strobe edges carry data
   wire edge_now = strobe_sync_reg[1] ^ strobe_last_reg;
   wire [DEPTH-1:0] taps = {line_reg, edge_now};
   // The edge is pushed into the data-valid window, and only on reads
   wire sample = taps[delay] && rd_en;

   assign rd_data = data_reg;
   assign rd_valid = valid_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strobe_sync_reg <= 2'b00;
         strobe_last_reg <= 1'b0;
         dq_meta_reg <= '0;
         dq_sync_reg <= '0;
         line_reg <= '0;
         data_reg <= '0;
         valid_reg <= 1'b0;
      end else begin
         strobe_sync_reg <= {strobe_sync_reg[0], strobe_pin};
         strobe_last_reg <= strobe_sync_reg[1];
         dq_meta_reg <= dq_pin;
         dq_sync_reg <= dq_meta_reg;
         line_reg <= taps[DEPTH-2:0];
         valid_reg <= sample;
         if (sample) begin
            data_reg <= dq_sync_reg;
         end
      end
   end

   property p_sample_data;
      @(posedge aclk) disable iff (!aresetn)
      sample |=> rd_valid && (rd_data == $past(dq_sync_reg));
   endproperty
   a_sample_data: assert property (p_sample_data)
      else $error("sampled data does not match delayed strobe");

   property p_reads_only;
      @(posedge aclk) disable iff (!aresetn)
      !rd_en |=> !rd_valid;
   endproperty
   a_reads_only: assert property (p_reads_only)
      else $error("strobe sampled outside a read");

   c_delayed: cover property (@(posedge aclk) disable iff (!aresetn)
      sample && (delay != '0));

endmodule : strobe_sampler

// ---- verif/sdram_strobe_model.sv ----
`timescale 1ns/1ps
module sdram_strobe_model #(
   parameter int DQ_W = 16,
   parameter int EDGES = 4
) (
   input wire logic go,
   input wire logic [DQ_W-1:0] base,
   output logic strobe_pin,
   output logic [DQ_W-1:0] dq_pin
);
   int i;
   initial begin
      strobe_pin = 1'b0;
      dq_pin = '0;
      forever begin
         @(posedge go);
         // Odd offset keeps the link phase unrelated to the bench clock
         #37;
         for (i = 0; i < EDGES; i++) begin
            // Strobe edge and new word leave together
            strobe_pin = ~strobe_pin;
            dq_pin = base + DQ_W'(i);
            #200;
         end
         // Released bus: stale value must not look valid
         dq_pin = ~dq_pin;
      end
   end
endmodule : sdram_strobe_model

// ---- verif/dram_refresh_ecc_control_test.sv ----
`timescale 1ns/1ps
module dram_refresh_ecc_control_test;
   import dram_ctl_pkg::*;
   localparam logic [2:0] KW = 3'h0, KR = 3'h1, KE = 3'h2, KC = 3'h3;
   localparam logic [2:0] KT = 3'h4;
   localparam int N_ROWS = 39;
   typedef struct {
      logic [2:0] kind;
      logic [7:0] idx;
      logic [15:0] val;
      logic [15:0] exp;
   } row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic tick = 1'b0, mem_busy = 1'b0, rd_en = 1'b0, go = 1'b0;
   logic refresh_issue, rd_valid, strobe_pin;
   logic [3:0] refresh_pending;
   logic [15:0] dq_pin, rd_data;
   logic [15:0] base = 16'hc3a5;
   ecc_check_t wr_check_in = '0;
   ecc_check_t wr_check_out;
   ecc_err_t rd_err = '0;
   int error_cnt = 0, n_checks = 0, k, j, n, cnt;
   logic [31:0] rd;
   logic [1:0] resp;
   row_t r;
   row_t rows [0:N_ROWS-1] = '{
      '{KR, 8'h82, 16'h0000, 16'h0080},
      '{KR, 8'h83, 16'h0000, 16'h000a},
      '{KR, 8'h84, 16'h0000, 16'h0000},
      '{KR, 8'h86, 16'h0000, 16'h0000},
      '{KR, 8'hc8, 16'h0000, 16'h0000},
      '{KR, 8'h90, 16'h0002, 16'h0000},
      '{KW, 8'h86, 16'h00ff, 16'h0000},
      '{KR, 8'h86, 16'h0000, 16'h0000},
      '{KW, 8'h84, 16'h00ff, 16'h0000},
      '{KC, 8'h00, 16'h003c, 16'h003c},
      '{KW, 8'h84, 16'h8001, 16'h0000},
      '{KC, 8'h00, 16'h00f0, 16'h00f1},
      '{KW, 8'h84, 16'h80a5, 16'h0000},
      '{KC, 8'h00, 16'h00ff, 16'h005a},
      '{KR, 8'h84, 16'h0000, 16'h80a5},
      '{KW, 8'h84, 16'h0000, 16'h0000},
      '{KC, 8'h00, 16'h0055, 16'h0055},
      '{KT, 8'h00, 16'h0107, 16'h0700},
      '{KT, 8'h00, 16'h0101, 16'h0008},
      '{KW, 8'h82, 16'h0030, 16'h0000},
      '{KR, 8'h82, 16'h0000, 16'h0030},
      '{KT, 8'h00, 16'h0102, 16'h0200},
      '{KT, 8'h00, 16'h0101, 16'h0003},
      '{KT, 8'h00, 16'h0001, 16'h0001},
      '{KE, 8'h00, 16'h0011, 16'h0000},
      '{KR, 8'h86, 16'h0000, 16'h0011},
      '{KR, 8'hc8, 16'h0000, 16'h0001},
      '{KE, 8'h00, 16'h0022, 16'h0000},
      '{KR, 8'h86, 16'h0000, 16'h0011},
      '{KE, 8'h00, 16'h0133, 16'h0000},
      '{KR, 8'h86, 16'h0000, 16'h0033},
      '{KR, 8'hc8, 16'h0000, 16'h0003},
      '{KE, 8'h00, 16'h0144, 16'h0000},
      '{KR, 8'h86, 16'h0000, 16'h0033},
      '{KW, 8'hc8, 16'h0003, 16'h0000},
      '{KR, 8'hc8, 16'h0000, 16'h0000},
      '{KE, 8'h00, 16'h0155, 16'h0000},
      '{KE, 8'h00, 16'h0066, 16'h0000},
      '{KR, 8'h86, 16'h0000, 16'h0055}
   };

   dram_refresh_ecc_control #(.DQ_W(16)) dram_refresh_ecc_control_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .refresh_tick(tick), .mem_busy(mem_busy),
      .refresh_issue(refresh_issue), .refresh_pending(refresh_pending),
      .strobe_pin(strobe_pin), .dq_pin(dq_pin), .rd_en(rd_en),
      .rd_data(rd_data), .rd_valid(rd_valid),
      .wr_check_in(wr_check_in), .wr_check_out(wr_check_out),
      .rd_err(rd_err)
   );

   sdram_strobe_model #(.DQ_W(16), .EDGES(4)) sdram_strobe_model_i (
      .go(go), .base(base), .strobe_pin(strobe_pin), .dq_pin(dq_pin)
   );

   initial begin
      forever #25 aclk = ~aclk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic timeout();
      error_cnt++;
      conclude();
   endtask : timeout

   task automatic axi_write(input logic [7:0] idx, input logic [31:0] d,
                            output logic [1:0] rs);
      int m;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (m = 0; m < 50; m++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      if (m == 50) timeout();
      rs = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] idx, output logic [31:0] d,
                           output logic [1:0] rs);
      int m;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (m = 0; m < 50; m++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      if (m == 50) timeout();
      d = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : axi_read

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (k = 0; k < N_ROWS; k++) begin
         r = rows[k];
         case (r.kind)
            KW: begin
               axi_write(r.idx, {16'h0000, r.val}, resp);
               check({30'h0, resp}, {16'h0000, r.exp});
            end
            KR: begin
               axi_read(r.idx, rd, resp);
               check(rd, {16'h0000, r.exp});
               check({30'h0, resp}, {16'h0000, r.val});
            end
            KE: begin
               @(posedge aclk);
               rd_err <= {1'b1, r.val[8], r.val[7:0]};
               @(posedge aclk);
               rd_err <= '0;
            end
            KC: begin
               @(posedge aclk);
               wr_check_in <= {1'b1, r.val[7:0]};
               @(posedge aclk);
               wr_check_in <= '0;
               @(negedge aclk);
               check({24'h0, wr_check_out.check}, {16'h0000, r.exp});
               check({31'h0, wr_check_out.valid}, 32'h0000_0001);
            end
            default: begin
               cnt = 0;
               for (j = 0; j < 40; j++) begin
                  @(posedge aclk);
                  mem_busy <= r.val[8];
                  tick <= (j < 2 * r.val[7:0]) && (j % 2 == 0);
                  @(negedge aclk);
                  // An unknown refresh_issue counts as an issue, not as silence
                  cnt += (refresh_issue === 1'b0) ? 0 : 1;
               end
               check(32'(cnt), {24'h0, r.exp[7:0]});
               check({28'h0, refresh_pending}, {28'h0, r.exp[11:8]});
            end
         endcase
      end
      // Reset in mid-run must restore register defaults
      axi_write(IDX_REFRESH_WM, 32'h0000_0050, resp);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(IDX_REFRESH_WM, rd, resp);
      check(rd, 32'h0000_0080);
      axi_read(IDX_SYNDROME, rd, resp);
      check(rd, 32'h0000_0000);
      // Software keeps the delay code within 0 to 7
      axi_write(IDX_STROBE, 32'h0000_0001, resp);
      @(posedge aclk);
      rd_en <= 1'b1;
      go <= 1'b1;
      for (n = 0; n < 60 && rd_valid !== 1'b1; n++) @(negedge aclk);
      if (n == 60) timeout();
      check({16'h0000, rd_data}, {16'h0000, base});
      // Every later strobe edge, rising or falling, carries the next word
      for (j = 1; j < 4; j++) begin
         @(negedge aclk);
         for (n = 0; n < 20 && rd_valid !== 1'b1; n++) @(negedge aclk);
         if (n == 20) timeout();
         check({16'h0000, rd_data}, {16'h0000, base + 16'(j)});
      end
      repeat (40) @(posedge aclk);
      rd_en <= 1'b0;
      go <= 1'b0;
      @(posedge aclk);
      go <= 1'b1;
      cnt = 0;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         cnt += (rd_valid === 1'b0) ? 0 : 1;
      end
      check(32'(cnt), 32'h0000_0000);
      conclude();
   end
endmodule : dram_refresh_ecc_control_test
